// ---- shared/rx_regs_pkg.sv ----
`default_nettype none
package rx_regs_pkg;
	// Geometry
	localparam int PORTS            = 8;
	localparam int SIG_BYTES        = 16;
	localparam int T1_CHANNELS      = 24;
	localparam int T1_SIG_HALF      = 12;
	localparam int E1_SIG_HALF      = 15;
	localparam logic [11:0] PORT_STRIDE = 12'h200;
	// Register indices inside one port window (byte address is four times index)
	localparam logic [8:0] MW_EN_IDX0   = 9'h03c;
	localparam logic [8:0] MW_EN_IDX2   = 9'h03e;
	localparam logic [8:0] SIG_IDX0     = 9'h040;
	localparam logic [8:0] SIG_IDX15    = 9'h04f;
	localparam logic [8:0] LINE_VIOL_HI = 9'h050;
	localparam logic [8:0] LINE_VIOL_LO = 9'h051;
	localparam logic [8:0] PATH_VIOL_HI = 9'h052;
	localparam logic [8:0] PATH_VIOL_LO = 9'h053;
	localparam logic [8:0] SYNC_LOSS_HI = 9'h054;
	localparam logic [8:0] SYNC_LOSS_LO = 9'h055;
	localparam logic [8:0] EBIT_HI      = 9'h056;
	localparam logic [8:0] EBIT_LO      = 9'h057;
	localparam logic [8:0] MONITOR_IDX  = 9'h060;
	localparam logic [8:0] REVISION_IDX = 9'h061;
	// Interrupt registers, only in the port 0 window
	localparam logic [8:0] IRQ_STAT_IDX = 9'h070;
	localparam logic [8:0] IRQ_MASK_IDX = 9'h071;
	// Reset values
	localparam logic [7:0]  MW_EN_RST    = 8'h00;
	localparam logic [15:0] COUNT_RST    = 16'h0000;
	localparam logic [15:0] COUNT_MAX    = 16'hffff;
	localparam logic [7:0]  MONITOR_RST  = 8'h00;
	localparam logic [7:0]  SIG_RST      = 8'h00;
	localparam logic [7:0]  IRQ_RST      = 8'h00;
	// Arbitrary neutral revision value
	localparam logic [7:0]  FW_REV_DEFAULT = 8'h01;
	// Digital milliwatt sequence, one byte per frame
	localparam logic [7:0] MW_CODE [8] = '{8'h1e, 8'h0b, 8'h0b, 8'h1e, 8'h9e, 8'h8b, 8'h8b, 8'h9e};

	// Per-port inputs from the framer core
	typedef struct packed {
		logic       out_of_frame;  // Receive sync lost
		logic       e1_mode;       // 1 = E1, 0 = T1
		logic       esf_mode;      // 1 = ESF, 0 = D4
		logic       line_viol;     // One pulse per line code violation
		logic       path_viol;     // One pulse per path code violation
		logic       sync_loss;     // One pulse per frame out of sync
		logic       ebit;          // One pulse per received E-bit error
		logic       sig_stb;       // Signaling nibble valid
		logic [4:0] sig_ch;        // Channel of the nibble
		logic [3:0] sig_abcd;      // A in bit 3
		logic       ts_stb;        // Timeslot byte valid
		logic [4:0] ts_ch;         // Timeslot number
		logic [7:0] ts_data;       // First received bit in bit 7
		logic [4:0] mon_sel;       // Monitored timeslot
	} rx_in_s;

	// Per-port receive data after milliwatt substitution
	typedef struct packed {
		logic       vld;
		logic [4:0] ch;
		logic [7:0] data;
	} rx_out_s;
endpackage
`default_nettype wire

// ---- hdl/rx_framer_status_counters.sv ----
// Function
// - Milliwatt code replaces enabled channel data, T1 mode only
// - One enable bit per T1 channel 1-24
// - Enable bytes at consecutive offsets from 0x3C
// - Eight port copies, stride 0x200
// - T1 signaling: channel n high, n+12 low
// - E1 signaling: XYXX byte, then n/n+15
// - ESF captures A, B, C, D per channel
// - D4 copies A, B into C, D
// - Signaling frozen while out of frame
// - Line code violation count at 0x50/0x51
// - Path code violation count at 0x52/0x53
// - Frames out of sync count at 0x54/0x55
// - E1 E-bit count at 0x56/0x57
// - Monitor byte shows selected timeslot data
// - First received bit in bit 7
// - Read-only firmware revision at 0x61
`timescale 1ns/10ps
`default_nettype none
module rx_framer_status_counters #(
	parameter logic [7:0] FW_REV = rx_regs_pkg::FW_REV_DEFAULT  // Arbitrary value
) (
	// Clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// Wishbone classic slave
	input  wire logic                         cyc_i,
	input  wire logic                         stb_i,
	input  wire logic                         we_i,
	input  wire logic [15:0]                  adr_i,
	input  wire logic [3:0]                   sel_i,
	input  wire logic [31:0]                  dat_i,
	output logic      [31:0]                  dat_o,
	output logic                              ack_o,
	// Framer side
	input  wire rx_regs_pkg::rx_in_s [7:0]    rx_i,
	output rx_regs_pkg::rx_out_s [7:0]        rx_o,
	// Interrupt
	output logic                              irq_o
);
	import rx_regs_pkg::*;

	// Stored state per port
	logic [23:0]          mw_en_r   [PORTS];     // Milliwatt enables, channel 1 in bit 0
	logic [15:0][7:0]     sig_r     [PORTS];     // Signaling snapshot bytes
	logic [15:0]          lcv_r     [PORTS];     // Line code violations
	logic [15:0]          pcv_r     [PORTS];     // Path code violations
	logic [15:0]          fos_r     [PORTS];     // Frames out of sync
	logic [15:0]          ebc_r     [PORTS];     // E-bit count
	logic [7:0]           mon_r     [PORTS];     // Monitored timeslot byte
	logic [2:0]           phase_r   [PORTS];     // Milliwatt sequence position
	logic [7:0]           irq_st_r;              // Sticky signaling change, one bit per port
	logic [7:0]           irq_mask_r;            // Interrupt enables
	logic                 ack_r;
	logic [31:0]          dat_r;

	// Bus decode
	logic                 req;                   // New access this cycle
	logic                 wr;                    // Write strobe, one cycle
	logic [2:0]           port;                  // Port window
	logic [8:0]           idx;                   // Register index in window
	logic                 in_range;              // Address within eight windows
	logic [7:0]           sig_set;               // Signaling change events

	// Map a channel to snapshot byte and nibble: {valid, upper, index}
	function automatic logic [5:0] sig_slot(input logic [4:0] ch, input logic e1);
		logic [4:0] t;
		t = 5'd0;
		if (e1) begin
			if (ch == 5'd0) begin
				sig_slot = {1'b1, 1'b0, 4'd0};  // XYXX bits in low nibble of byte 0
			end else if (ch <= 5'(E1_SIG_HALF)) begin
				sig_slot = {1'b1, 1'b1, ch[3:0]};
			end else if (ch <= 5'(2 * E1_SIG_HALF)) begin
				t = ch - 5'(E1_SIG_HALF);
				sig_slot = {1'b1, 1'b0, t[3:0]};
			end else begin
				sig_slot = 6'h00;
			end
		end else begin
			if (ch == 5'd0 || ch > 5'(T1_CHANNELS)) begin
				sig_slot = 6'h00;
			end else if (ch <= 5'(T1_SIG_HALF)) begin
				t = ch - 5'd1;
				sig_slot = {1'b1, 1'b1, t[3:0]};
			end else begin
				t = ch - 5'(T1_SIG_HALF + 1);
				sig_slot = {1'b1, 1'b0, t[3:0]};
			end
		end
	endfunction

	// Saturating count step; wrapping would hide a long error burst
	function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic ev);
		sat_inc = (ev && v != COUNT_MAX) ? v + 16'd1 : v;
	endfunction

	// Bus address split into port and index
	always_comb begin
		req      = cyc_i && stb_i && !ack_r;
		wr       = req && we_i;
		port     = adr_i[13:11];
		idx      = adr_i[10:2];
		in_range = (adr_i[15:14] == 2'b00) && (adr_i[1:0] == 2'b00);
	end

	// Acknowledge one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end
	assign ack_o = ack_r;

	// Read mux; unmapped addresses answer zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 32'h0000_0000;
		end else if (req && !we_i) begin
			dat_r <= 32'h0000_0000;
			if (in_range) begin
				if (idx >= MW_EN_IDX0 && idx <= MW_EN_IDX2) begin
					dat_r[7:0] <= mw_en_r[port][8 * (idx - MW_EN_IDX0) +: 8];
				end else if (idx >= SIG_IDX0 && idx <= SIG_IDX15) begin
					dat_r[7:0] <= sig_r[port][idx[3:0]];
				end else begin
					case (idx)
						LINE_VIOL_HI: dat_r[7:0] <= lcv_r[port][15:8];
						LINE_VIOL_LO: dat_r[7:0] <= lcv_r[port][7:0];
						PATH_VIOL_HI: dat_r[7:0] <= pcv_r[port][15:8];
						PATH_VIOL_LO: dat_r[7:0] <= pcv_r[port][7:0];
						SYNC_LOSS_HI: dat_r[7:0] <= fos_r[port][15:8];
						SYNC_LOSS_LO: dat_r[7:0] <= fos_r[port][7:0];
						EBIT_HI:      dat_r[7:0] <= ebc_r[port][15:8];
						EBIT_LO:      dat_r[7:0] <= ebc_r[port][7:0];
						MONITOR_IDX:  dat_r[7:0] <= mon_r[port];
						REVISION_IDX: dat_r[7:0] <= FW_REV;
						IRQ_STAT_IDX: dat_r[7:0] <= (port == 3'd0) ? irq_st_r : 8'h00;
						IRQ_MASK_IDX: dat_r[7:0] <= (port == 3'd0) ? irq_mask_r : 8'h00;
						default:      dat_r[7:0] <= 8'h00;
					endcase
				end
			end
		end
	end
	assign dat_o = dat_r;

	// Milliwatt enable bytes, the only writable per-port registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int p = 0; p < PORTS; p++) begin
				mw_en_r[p] <= {3{MW_EN_RST}};
			end
		end else if (wr && in_range && sel_i[0] && idx >= MW_EN_IDX0 && idx <= MW_EN_IDX2) begin
			// Other offsets in the window fall through untouched
			mw_en_r[port][8 * (idx - MW_EN_IDX0) +: 8] <= dat_i[7:0];
		end
	end

	// Receive data path with milliwatt substitution, T1 channels only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int p = 0; p < PORTS; p++) begin
				rx_o[p]    <= '0;
				phase_r[p] <= 3'd0;
			end
		end else begin
			for (int p = 0; p < PORTS; p++) begin
				rx_o[p].vld <= rx_i[p].ts_stb;
				rx_o[p].ch  <= rx_i[p].ts_ch;
				if (rx_i[p].ts_stb) begin
					if (!rx_i[p].e1_mode && rx_i[p].ts_ch != 5'd0 && rx_i[p].ts_ch <= 5'(T1_CHANNELS)
						&& mw_en_r[p][rx_i[p].ts_ch - 5'd1]) begin
						rx_o[p].data <= MW_CODE[phase_r[p]];
					end else begin
						rx_o[p].data <= rx_i[p].ts_data;
					end
					// Sequence advances once per frame, at channel 1
					if (rx_i[p].ts_ch == 5'd1) begin
						phase_r[p] <= phase_r[p] + 3'd1;
					end
				end
			end
		end
	end

	// Signaling snapshot capture
	always_ff @(posedge clk_i) begin
		logic [5:0] slot;
		logic [3:0] nib;
		slot = 6'h00;
		nib  = 4'h0;
		if (rst_i) begin
			for (int p = 0; p < PORTS; p++) begin
				sig_r[p] <= {SIG_BYTES{SIG_RST}};
			end
		end else begin
			for (int p = 0; p < PORTS; p++) begin
				slot = sig_slot(rx_i[p].sig_ch, rx_i[p].e1_mode);
				// D4 carries only A and B; repeat them in C and D
				nib  = (rx_i[p].esf_mode || rx_i[p].e1_mode) ? rx_i[p].sig_abcd
					: {rx_i[p].sig_abcd[3:2], rx_i[p].sig_abcd[3:2]};
				// Frozen while out of frame so the last good values stay
				if (rx_i[p].sig_stb && !rx_i[p].out_of_frame && slot[5]) begin
					if (slot[4]) begin
						sig_r[p][slot[3:0]][7:4] <= nib;
					end else if (rx_i[p].e1_mode && slot[3:0] == 4'd0) begin
						sig_r[p][0] <= {4'h0, nib};
					end else begin
						sig_r[p][slot[3:0]][3:0] <= nib;
					end
				end
			end
		end
	end

	// Change events for the interrupt status
	always_comb begin
		logic [5:0] s;
		logic [3:0] n;
		s = 6'h00;
		n = 4'h0;
		for (int p = 0; p < PORTS; p++) begin
			s = sig_slot(rx_i[p].sig_ch, rx_i[p].e1_mode);
			n = (rx_i[p].esf_mode || rx_i[p].e1_mode) ? rx_i[p].sig_abcd
				: {rx_i[p].sig_abcd[3:2], rx_i[p].sig_abcd[3:2]};
			sig_set[p] = rx_i[p].sig_stb && !rx_i[p].out_of_frame && s[5]
				&& (s[4] ? sig_r[p][s[3:0]][7:4] != n : sig_r[p][s[3:0]][3:0] != n);
		end
	end

	// Performance counters; host writes never reach them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int p = 0; p < PORTS; p++) begin
				lcv_r[p] <= COUNT_RST;
				pcv_r[p] <= COUNT_RST;
				fos_r[p] <= COUNT_RST;
				ebc_r[p] <= COUNT_RST;
			end
		end else begin
			for (int p = 0; p < PORTS; p++) begin
				lcv_r[p] <= sat_inc(lcv_r[p], rx_i[p].line_viol);
				pcv_r[p] <= sat_inc(pcv_r[p], rx_i[p].path_viol);
				fos_r[p] <= sat_inc(fos_r[p], rx_i[p].sync_loss);
				// E-bits exist only in E1 framing
				ebc_r[p] <= sat_inc(ebc_r[p], rx_i[p].ebit && rx_i[p].e1_mode);
			end
		end
	end

	// Timeslot monitor capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int p = 0; p < PORTS; p++) begin
				mon_r[p] <= MONITOR_RST;
			end
		end else begin
			for (int p = 0; p < PORTS; p++) begin
				// Byte arrives first bit in bit 7, kept as is
				if (rx_i[p].ts_stb && rx_i[p].ts_ch == rx_i[p].mon_sel) begin
					mon_r[p] <= rx_i[p].ts_data;
				end
			end
		end
	end

	// Interrupt status and mask; a set in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_st_r   <= IRQ_RST;
			irq_mask_r <= IRQ_RST;
		end else begin
			if (wr && in_range && sel_i[0] && port == 3'd0 && idx == IRQ_STAT_IDX) begin
				irq_st_r <= (irq_st_r & ~dat_i[7:0]) | sig_set;
			end else begin
				irq_st_r <= irq_st_r | sig_set;
			end
			if (wr && in_range && sel_i[0] && port == 3'd0 && idx == IRQ_MASK_IDX) begin
				irq_mask_r <= dat_i[7:0];
			end
		end
	end
	assign irq_o = |(irq_st_r & irq_mask_r);

	// Checks on port 0 and the bus
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic mw_hit0;
	assign mw_hit0 = rx_i[0].ts_stb && !rx_i[0].e1_mode && rx_i[0].ts_ch != 5'd0
		&& rx_i[0].ts_ch <= 5'(T1_CHANNELS) && mw_en_r[0][rx_i[0].ts_ch - 5'd1];

	sequence s_rev_read;
		cyc_i && stb_i && !we_i && !ack_o && adr_i == {2'b00, 3'd0, REVISION_IDX, 2'b00};
	endsequence

	chk_mw_substitute: assert property (mw_hit0 |=> rx_o[0].data == MW_CODE[$past(phase_r[0])])
		else $error("milliwatt code not substituted");
	chk_mw_passthru: assert property (rx_i[0].ts_stb && !mw_hit0 |=> rx_o[0].data == $past(rx_i[0].ts_data))
		else $error("receive data altered without enable");
	chk_sig_freeze: assert property (rx_i[0].out_of_frame |=> $stable(sig_r[0]))
		else $error("signaling changed while out of frame");
	chk_d4_copy: assert property (rx_i[0].sig_stb && !rx_i[0].out_of_frame && !rx_i[0].esf_mode
		&& !rx_i[0].e1_mode && rx_i[0].sig_ch == 5'd13
		|=> sig_r[0][0][3:0] == {2{$past(rx_i[0].sig_abcd[3:2])}})
		else $error("D4 A/B not repeated in C/D");
	chk_t1_upper: assert property (rx_i[0].sig_stb && !rx_i[0].out_of_frame && !rx_i[0].e1_mode
		&& rx_i[0].esf_mode && rx_i[0].sig_ch == 5'd12 |=> sig_r[0][11][7:4] == $past(rx_i[0].sig_abcd))
		else $error("T1 channel 12 not in byte 11 upper nibble");
	chk_line_count: assert property (rx_i[0].line_viol && lcv_r[0] != COUNT_MAX |=> lcv_r[0] == $past(lcv_r[0]) + 16'd1)
		else $error("line violation count did not step");
	chk_ebit_t1: assert property (!rx_i[0].e1_mode |=> $stable(ebc_r[0]))
		else $error("E-bit count moved in T1 mode");
	chk_monitor_sel: assert property (rx_i[0].ts_stb && rx_i[0].ts_ch == rx_i[0].mon_sel
		|=> mon_r[0] == $past(rx_i[0].ts_data))
		else $error("monitor byte not captured");
	chk_rev_read: assert property (s_rev_read |=> ack_o && dat_o == {24'h000000, FW_REV})
		else $error("revision read wrong");
	chk_ro_write: assert property (wr && adr_i[10:2] == LINE_VIOL_HI && !rx_i[0].line_viol
		&& adr_i[13:11] == 3'd0 |=> $stable(lcv_r[0]))
		else $error("counter changed by host write");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held two cycles");

	// A fresh request on the bus; the slave answers one cycle later
	sequence s_take;
		cyc_i && stb_i && !ack_o;
	endsequence

	// Nibble accepted on port 0 for a given mode and channel
	sequence s_e1_word;
		rx_i[0].sig_stb && !rx_i[0].out_of_frame && rx_i[0].e1_mode && rx_i[0].sig_ch == 5'd0;
	endsequence

	sequence s_esf_ch1;
		rx_i[0].sig_stb && !rx_i[0].out_of_frame && !rx_i[0].e1_mode
		&& rx_i[0].esf_mode && rx_i[0].sig_ch == 5'd1;
	endsequence

	// Master waits on ack only, so a missing answer would hang the bus
	chk_ack_answer: assert property (s_take |=> ack_o)
		else $error("request not acknowledged");
	// E1 framing word sits alone in the low nibble of byte 0
	chk_e1_xyxx: assert property (s_e1_word |=> sig_r[0][0] == {4'h0, $past(rx_i[0].sig_abcd)})
		else $error("E1 XYXX byte wrong");
	// ESF keeps all four bits as received
	chk_esf_keep: assert property (s_esf_ch1 |=> sig_r[0][0][7:4] == $past(rx_i[0].sig_abcd))
		else $error("ESF nibble not kept");
	// Path count steps once per pulse below saturation
	chk_path_count: assert property (rx_i[0].path_viol && pcv_r[0] != COUNT_MAX
		|=> pcv_r[0] == $past(pcv_r[0]) + 16'd1)
		else $error("path violation count did not step");
	// Enable byte written by the host lands in the right place
	chk_mw_write: assert property (wr && in_range && sel_i[0] && port == 3'd0 && idx == MW_EN_IDX0
		|=> mw_en_r[0][7:0] == $past(dat_i[7:0]))
		else $error("milliwatt enable write lost");
	// A change event always reaches the sticky status, even during a clear
	chk_irq_set: assert property (sig_set[0] |=> irq_st_r[0])
		else $error("signaling change not latched");
endmodule
`default_nettype wire

// ---- verif/wb_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Host processor stand-in: classic single-cycle bus master
module wb_host_model (
	// Clock
	input  wire logic        clk_i,
	// Bus master side
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [15:0]      adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o,
	input  wire logic [31:0] dat_i,
	input  wire logic        ack_i
);
	// Idle bus from time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 16'h0000;
		sel_o = 4'h0;
		dat_o = 32'h0000_0000;
	end

	// One transfer; ack is polled on every rising clock edge
	task automatic xfer(input logic w, input logic [2:0] p, input logic [8:0] idx,
		input logic [7:0] wd, output logic [31:0] rd);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= {2'b00, p, idx, 2'b00};
		sel_o <= 4'h1;
		dat_o <= {24'h000000, wd};
		// Hold until ack; the bench watchdog bounds a hang
		do @(posedge clk_i); while (ack_i !== 1'b1);
		rd = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- verif/test_rx_framer_status_counters.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_rx_framer_status_counters;
	import rx_regs_pkg::*;
	// Clock, reset, bus
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [15:0] adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        irq;
	// Framer side
	rx_in_s  [7:0] rx;
	rx_out_s [7:0] rxo;
	// Scoreboard
	int          fail_count;
	int          tests_run;
	logic [31:0] rd;
	rx_in_s      vr;
	// Rows: port, event kind, E1 mode, pulses, expected count
	localparam int NR = 5;
	logic [2:0]  r_port [NR] = '{3'h0, 3'h0, 3'h3, 3'h5, 3'h6};
	logic [1:0]  r_kind [NR] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
	logic        r_e1   [NR] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	int          r_n    [NR] = '{3, 2, 5, 4, 2};
	logic [15:0] r_exp  [NR] = '{16'h0003, 16'h0002, 16'h0005, 16'h0004, 16'h0000};

	rx_framer_status_counters DUT (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .rx_i(rx), .rx_o(rxo), .irq_o(irq));
	wb_host_model host (
		.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(wdat), .dat_i(rdat), .ack_i(ack));

	// 125 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Register read with compare, register write
	task automatic rdc(input logic [2:0] p, input logic [8:0] idx, input logic [7:0] e, input string what);
		host.xfer(1'b0, p, idx, 8'h00, rd);
		chk(rd, {24'h000000, e}, what);
	endtask
	task automatic wr(input logic [2:0] p, input logic [8:0] idx, input logic [7:0] d);
		host.xfer(1'b1, p, idx, d, rd);
	endtask
	// One-cycle strobe; levels stay, pulses drop
	task automatic pulse(input logic [2:0] p, input rx_in_s v);
		rx_in_s q;
		q = v;
		{q.line_viol, q.path_viol, q.sync_loss, q.ebit, q.sig_stb, q.ts_stb} = 6'h00;
		@(posedge clk_i);
		rx[p] <= v;
		@(posedge clk_i);
		rx[p] <= q;
		#1;
	endtask
	// Signaling nibble with mode {out_of_frame, e1, esf}
	task automatic sig(input logic [2:0] p, input logic [2:0] m, input logic [4:0] ch, input logic [3:0] a);
		rx_in_s v;
		v = rx[p];
		{v.out_of_frame, v.e1_mode, v.esf_mode} = m;
		v.sig_stb = 1'b1;
		v.sig_ch = ch;
		v.sig_abcd = a;
		pulse(p, v);
	endtask
	// Timeslot byte; the output lands one cycle later
	task automatic ts(input logic [2:0] p, input logic [4:0] ch, input logic [7:0] d, input logic [7:0] e);
		rx_in_s v;
		v = rx[p];
		v.ts_stb = 1'b1;
		v.ts_ch = ch;
		v.ts_data = d;
		pulse(p, v);
		chk({23'h0, rxo[p].vld, rxo[p].data}, {23'h0, 1'b1, e}, "rx data");
	endtask
	// Verdict, the only exit
	task automatic summarize;
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#160000;
		fail_count++;
		$display("ERROR %0t: timeout", $time);
		summarize();
	end

	// Main sequence
	initial begin
		rst_i = 1'b1;
		rx = '0;
		fail_count = 0;
		tests_run = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		// Row table: pulses in, counter pair out
		for (int i = 0; i < NR; i++) begin
			vr = rx[r_port[i]];
			vr.e1_mode = r_e1[i];
			{vr.line_viol, vr.path_viol, vr.sync_loss, vr.ebit} = 4'h8 >> r_kind[i];
			repeat (r_n[i]) pulse(r_port[i], vr);
			rdc(r_port[i], LINE_VIOL_HI + {6'h0, r_kind[i], 1'b0}, r_exp[i][15:8], "count hi");
			rdc(r_port[i], LINE_VIOL_LO + {6'h0, r_kind[i], 1'b0}, r_exp[i][7:0], "count lo");
		end
		// Read-only places and an unmapped one
		rdc(3'h0, REVISION_IDX, FW_REV_DEFAULT, "revision");
		wr(3'h0, LINE_VIOL_HI, 8'haa);
		rdc(3'h0, LINE_VIOL_HI, 8'h00, "count hi kept");
		wr(3'h2, REVISION_IDX, 8'hff);
		wr(3'h0, LINE_VIOL_LO, 8'h55);
		rdc(3'h2, REVISION_IDX, FW_REV_DEFAULT, "revision kept");
		rdc(3'h0, LINE_VIOL_LO, 8'h03, "count kept");
		rdc(3'h0, 9'h010, 8'h00, "unmapped");
		// Signaling: T1 ESF, T1 D4, frozen, E1
		sig(3'h1, 3'h1, 5'h01, 4'ha);
		sig(3'h1, 3'h1, 5'h0d, 4'h5);
		rdc(3'h1, SIG_IDX0, 8'ha5, "t1 esf");
		sig(3'h1, 3'h0, 5'h02, 4'h8);
		rdc(3'h1, SIG_IDX0 + 9'h001, 8'ha0, "d4 copy");
		sig(3'h1, 3'h4, 5'h01, 4'h1);
		rdc(3'h1, SIG_IDX0, 8'ha5, "frozen");
		sig(3'h2, 3'h2, 5'h00, 4'hb);
		sig(3'h2, 3'h2, 5'h10, 4'h6);
		sig(3'h2, 3'h2, 5'h0f, 4'hc);
		rdc(3'h2, SIG_IDX0, 8'h0b, "e1 first");
		rdc(3'h2, SIG_IDX0 + 9'h001, 8'h06, "e1 ch16");
		rdc(3'h2, SIG_IDX15, 8'hc0, "e1 ch15");
		// Interrupt: ports 1 and 2 changed, masked, enabled, cleared
		chk({31'h0, irq}, 32'h0, "irq masked");
		rdc(3'h0, IRQ_STAT_IDX, 8'h06, "irq status");
		wr(3'h0, IRQ_MASK_IDX, 8'h02);
		chk({31'h0, irq}, 32'h1, "irq on");
		wr(3'h0, IRQ_STAT_IDX, 8'h02);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		rdc(3'h0, IRQ_STAT_IDX, 8'h04, "irq status left");
		// Milliwatt on channels 1 and 24 of port 0
		wr(3'h0, MW_EN_IDX0, 8'h01);
		wr(3'h0, MW_EN_IDX2, 8'h80);
		rdc(3'h0, MW_EN_IDX0, 8'h01, "mw enable");
		ts(3'h0, 5'h01, 8'h55, MW_CODE[0]);
		ts(3'h0, 5'h02, 8'h55, 8'h55);
		ts(3'h0, 5'h01, 8'h55, MW_CODE[1]);
		ts(3'h0, 5'h18, 8'h33, MW_CODE[2]);
		// Monitor timeslot 5 of port 0
		@(posedge clk_i);
		rx[0].mon_sel <= 5'h05;
		#1;
		ts(3'h0, 5'h05, 8'ha7, 8'ha7);
		ts(3'h0, 5'h06, 8'h11, 8'h11);
		rdc(3'h0, MONITOR_IDX, 8'ha7, "monitor");
		// Port 0 signaling: ESF, D4, frozen, then E1 framing word
		sig(3'h0, 3'h1, 5'h0c, 4'h9);
		sig(3'h0, 3'h1, 5'h01, 4'h6);
		sig(3'h0, 3'h0, 5'h0d, 4'h4);
		rdc(3'h0, SIG_IDX0, 8'h65, "port0 sig");
		rdc(3'h0, SIG_IDX0 + 9'h00b, 8'h90, "t1 ch12");
		sig(3'h0, 3'h4, 5'h0c, 4'h3);
		rdc(3'h0, SIG_IDX0 + 9'h00b, 8'h90, "frozen ch12");
		sig(3'h0, 3'h2, 5'h00, 4'h7);
		rdc(3'h0, SIG_IDX0, 8'h07, "e1 xyxx");
		// Second reset mid-run
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(3'h0, LINE_VIOL_LO, 8'h00, "count reset");
		rdc(3'h0, MW_EN_IDX0, 8'h00, "mw reset");
		rdc(3'h1, SIG_IDX0, 8'h00, "sig reset");
		chk({31'h0, irq}, 32'h0, "irq reset");
		summarize();
	end
endmodule
`default_nettype wire
